/* File: hdl/rsic_top.v */
`timescale 1ns/1ps
`include "rsic_consts.vh"
module rsic_top (
  input wire CLOCK,
  input wire RST_N,
  input wire [3:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  output reg [31:0] RDATA,
  input wire LOCAL_BUS_IRQ_IN_N,
  output wire HOST_IRQ_FIRST_N,
  output wire HOST_IRQ_FIRST_OE,
  output wire HOST_IRQ_SECOND_N,
  output wire HOST_IRQ_SECOND_OE,
  input wire DESC_QUEUED,
  input wire QUEUE_FULL,
  input wire FETCH_GLOBAL_DONE,
  input wire FETCH_IQ_DONE,
  input wire TX_LINE_CLOCK,
  input wire RX_LINE_CLOCK,
  output wire TX_SERIAL_DATA_OE,
  output wire PORTS_RUN,
  output reg ACK_PULSE,
  output reg [4:0] OP_PULSE
);
  reg [31:0] global_reg;
  reg [31:0] group_reg;
  reg [31:0] port_reg;
  reg [31:0] prot_reg;
  reg [31:0] mlen_reg;
  reg [31:0] sreq_reg;
  reg [31:0] iqptr_reg;
  reg [31:0] iqlen_reg;
  reg [15:0] next_irq_offset_reg;
  reg irq_queue_full_flag_reg;
  reg [14:0] irq_pending_count_reg;
  reg [14:0] irq_pending_count_next;
  reg [31:0] wr_index_reg;
  reg tx_active_reg;
  reg rx_active_reg;
  reg tx_pend_reg;
  reg rx_pend_reg;
  reg [1:0] fetch_reg;
  reg gi_wait_reg;
  reg chip_reset_reg;

  wire wr_sreq = WR && (ADDR == `RSIC_A_SREQ);
  wire [4:0] op = WDATA[`RSIC_SR_OP_LSB+4:`RSIC_SR_OP_LSB];
  wire dir_tx = WDATA[`RSIC_SR_DIR_BIT];
  wire tx_done;
  wire rx_done;

  // Operation decoder, used at write; the strobe output carries the raw opcode
  function [6:0] rsic_decode;
    input [4:0] code;
    input tx;
    begin
      rsic_decode = 7'h00;
      case (code)
        `RSIC_OP_CHIP_RESET: rsic_decode[0] = 1'b1;
        `RSIC_OP_GROUP_RESET: rsic_decode[tx ? 2 : 1] = 1'b1;
        `RSIC_OP_CH_ACT: rsic_decode[3] = 1'b1;
        `RSIC_OP_CH_DEACT: rsic_decode[4] = 1'b1;
        `RSIC_OP_GLOBAL_INIT: rsic_decode[5] = 1'b1;
        `RSIC_OP_GROUP_INIT: rsic_decode[6] = 1'b1;
        default: rsic_decode = 7'h00;
      endcase
    end
  endfunction

  wire [6:0] dec = wr_sreq ? rsic_decode(op, dir_tx) : 7'h00;
  wire do_scr = dec[0];

  //////////////////////////////////////////////////////////////////////
  // Configuration registers and soft chip reset clearing
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      // Hard reset also zeroes the global mapping bits and the interrupt queue registers that a soft chip reset keeps
      global_reg <= `RSIC_ZERO;
      group_reg <= `RSIC_GRP_MASKS;
      port_reg <= `RSIC_ZERO;
      prot_reg <= `RSIC_ZERO;
      mlen_reg <= `RSIC_ZERO;
      sreq_reg <= `RSIC_ZERO;
      iqptr_reg <= `RSIC_ZERO;
      iqlen_reg <= `RSIC_ZERO;
      wr_index_reg <= `RSIC_ZERO;
      chip_reset_reg <= 1'b1;
    end else if (do_scr) begin
      global_reg <= global_reg & `RSIC_PMAP_MASK;
      group_reg <= `RSIC_GRP_MASKS;
      port_reg <= `RSIC_ZERO;
      prot_reg <= `RSIC_ZERO;
      mlen_reg <= `RSIC_ZERO;
      sreq_reg <= `RSIC_ZERO;
      wr_index_reg <= `RSIC_ZERO;
      chip_reset_reg <= 1'b1;
    end else begin
      if (WR) begin
        case (ADDR)
          `RSIC_A_GLOBAL: global_reg <= WDATA;
          `RSIC_A_GROUP: group_reg <= WDATA;
          `RSIC_A_PORT: port_reg <= WDATA;
          `RSIC_A_PROT: prot_reg <= WDATA;
          `RSIC_A_MLEN: mlen_reg <= WDATA;
          `RSIC_A_SREQ: sreq_reg <= WDATA;
          `RSIC_A_IQPTR: iqptr_reg <= WDATA;
          `RSIC_A_IQLEN: iqlen_reg <= WDATA;
          default: ;
        endcase
      end
      if (DESC_QUEUED)
        wr_index_reg <= wr_index_reg + 32'h1;
      if (dec[5])
        chip_reset_reg <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Interrupt status word
  always @* begin
    irq_pending_count_next = irq_pending_count_reg;
    if (RD && ADDR == `RSIC_A_ISTAT)
      irq_pending_count_next = {`RSIC_IS_CNT_W{1'b0}};
    if (DESC_QUEUED)
      irq_pending_count_next = irq_pending_count_next + 15'h1;
  end

  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      next_irq_offset_reg <= 16'h0000;
      irq_queue_full_flag_reg <= 1'b0;
      irq_pending_count_reg <= 15'h0000;
    end else if (do_scr) begin
      next_irq_offset_reg <= 16'h0000;
      irq_queue_full_flag_reg <= 1'b0;
      irq_pending_count_reg <= 15'h0000;
    end else begin
      irq_pending_count_reg <= irq_pending_count_next;
      irq_queue_full_flag_reg <= QUEUE_FULL;
      if (WR && ADDR == `RSIC_A_ISTAT)
        next_irq_offset_reg <= WDATA[31:`RSIC_IS_NEXT_LSB];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Channel activity and pending deactivation per direction
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tx_active_reg <= 1'b0;
      rx_active_reg <= 1'b0;
      tx_pend_reg <= 1'b1;
      rx_pend_reg <= 1'b1;
    end else begin
      if (do_scr || dec[2]) begin
        tx_pend_reg <= 1'b1;
      end else if (tx_done) begin
        tx_pend_reg <= 1'b0;
        tx_active_reg <= 1'b0;
      end else if (dec[3] && !tx_pend_reg) begin
        tx_active_reg <= 1'b1;
      end else if (dec[4]) begin
        tx_active_reg <= 1'b0;
      end
      if (do_scr || dec[1]) begin
        rx_pend_reg <= 1'b1;
      end else if (rx_done) begin
        rx_pend_reg <= 1'b0;
        rx_active_reg <= 1'b0;
      end else if (dec[3] && !rx_pend_reg) begin
        rx_active_reg <= 1'b1;
      end else if (dec[4]) begin
        rx_active_reg <= 1'b0;
      end
    end
  end

  rsic_edge_cnt u_tx_cnt (
    .clk(CLOCK),
    .rst_n(RST_N),
    .start(do_scr | dec[2]),
    .line_clk(TX_LINE_CLOCK),
    .done(tx_done)
  );

  rsic_edge_cnt u_rx_cnt (
    .clk(CLOCK),
    .rst_n(RST_N),
    .start(do_scr | dec[1]),
    .line_clk(RX_LINE_CLOCK),
    .done(rx_done)
  );

  //////////////////////////////////////////////////////////////////////
  // Acknowledge generation; none for chip reset
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      fetch_reg <= 2'h0;
      gi_wait_reg <= 1'b0;
      ACK_PULSE <= 1'b0;
      OP_PULSE <= 5'h00;
    end else begin
      ACK_PULSE <= 1'b0;
      OP_PULSE <= wr_sreq ? op : `RSIC_OP_NOP;
      if (dec[5]) begin
        gi_wait_reg <= 1'b1;
        fetch_reg <= 2'h0;
      end else if (gi_wait_reg) begin
        if (fetch_reg == `RSIC_FETCH_DONE) begin
          ACK_PULSE <= 1'b1;
          gi_wait_reg <= 1'b0;
        end
        fetch_reg <= fetch_reg | {FETCH_IQ_DONE, FETCH_GLOBAL_DONE};
      end else if (wr_sreq && !do_scr && op != `RSIC_OP_NOP) begin
        ACK_PULSE <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Register read port, data one cycle later
  always @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= `RSIC_ZERO;
    end else if (RD) begin
      case (ADDR)
        `RSIC_A_GLOBAL: RDATA <= global_reg;
        `RSIC_A_ISTAT: RDATA <= {next_irq_offset_reg, irq_queue_full_flag_reg, irq_pending_count_reg};
        `RSIC_A_GROUP: RDATA <= group_reg;
        `RSIC_A_PORT: RDATA <= port_reg;
        `RSIC_A_PROT: RDATA <= prot_reg;
        `RSIC_A_MLEN: RDATA <= mlen_reg;
        `RSIC_A_SREQ: RDATA <= sreq_reg;
        `RSIC_A_IQPTR: RDATA <= iqptr_reg;
        `RSIC_A_IQLEN: RDATA <= iqlen_reg;
        `RSIC_A_STATUS: RDATA <= {26'h0, chip_reset_reg, gi_wait_reg, tx_pend_reg, rx_pend_reg,
          tx_active_reg, rx_active_reg};
        `RSIC_A_EVENT: RDATA <= wr_index_reg;
        default: RDATA <= `RSIC_ONES;
      endcase
    end else begin
      RDATA <= `RSIC_ZERO;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Host interrupt pins, open drain; second passes the local bus irq through outside reset
  assign HOST_IRQ_FIRST_N = 1'b0;
  assign HOST_IRQ_FIRST_OE = RST_N && (irq_pending_count_reg != 15'h0000);
  assign HOST_IRQ_SECOND_N = 1'b0;
  assign HOST_IRQ_SECOND_OE = RST_N && !LOCAL_BUS_IRQ_IN_N;
  // Transmit data floats while reset or transmit deactivated
  assign TX_SERIAL_DATA_OE = RST_N && tx_active_reg && !tx_pend_reg && group_reg[`RSIC_GRP_TXEN];
  assign PORTS_RUN = RST_N && !chip_reset_reg;
endmodule

/* File: hdl/rsic_consts.vh */
// Notes on behaviour
// - Second host irq follows local bus irq
// - Local bus irq queues no descriptor
// - Status read reports only new descriptors
// - Hard reset floats outputs, halts all
// - Hard reset completes in one clock
// - Hard reset also enters soft chip reset
// - Chip reset stops ports, keeps host state
// - Chip reset clears global word except mapping
// - Chip reset zeroes whole interrupt status word
// - Chip reset clears group word, alarm masks set
// - Chip reset zeroes write index, keeps queue
// - Channels deactivate after two line clocks
// - Chip reset zeroes port, protect, length, request
// - No acknowledge descriptor for chip reset
// - Group reset deactivates one direction; a transmit one floats data
// - Global init ack after both descriptors fetched
// - Status read clears count, first irq drops
`ifndef RSIC_CONSTS_VH
`define RSIC_CONSTS_VH

// Register indexes (word addresses on the plain port)
`define RSIC_A_GLOBAL 4'h0
`define RSIC_A_ISTAT 4'h1
`define RSIC_A_GROUP 4'h2
`define RSIC_A_PORT 4'h3
`define RSIC_A_PROT 4'h4
`define RSIC_A_MLEN 4'h5
`define RSIC_A_SREQ 4'h6
`define RSIC_A_IQPTR 4'h7
`define RSIC_A_IQLEN 4'h8
`define RSIC_A_STATUS 4'h9
`define RSIC_A_EVENT 4'ha

// Global word field
`define RSIC_PMAP_MASK 32'h0000_0003

// Group word alarm masks (bits 0 and 1 enable rx/tx)
`define RSIC_GRP_MASKS 32'h0000_0300
`define RSIC_GRP_RXEN 0
`define RSIC_GRP_TXEN 1

// Interrupt status fields
`define RSIC_IS_NEXT_LSB 16
`define RSIC_IS_FULL_BIT 15
`define RSIC_IS_CNT_W 15

// Service request fields
`define RSIC_SR_OP_LSB 8
`define RSIC_SR_DIR_BIT 5
`define RSIC_OP_NOP 5'h00
`define RSIC_OP_GLOBAL_INIT 5'h01
`define RSIC_OP_GROUP_INIT 5'h02
`define RSIC_OP_CHIP_RESET 5'h03
`define RSIC_OP_GROUP_RESET 5'h04
`define RSIC_OP_CH_ACT 5'h05
`define RSIC_OP_CH_DEACT 5'h06

// Misc
`define RSIC_ZERO 32'h0000_0000
`define RSIC_ONES 32'hffff_ffff
`define RSIC_LINE_EDGES 2'h2
`define RSIC_FETCH_DONE 2'h3

`endif

/* File: hdl/rsic_edge_cnt.v */
`timescale 1ns/1ps
`include "rsic_consts.vh"
module rsic_edge_cnt (
  input wire clk,
  input wire rst_n,
  input wire start,
  input wire line_clk,
  output wire done
);
  reg sync1_reg;
  reg sync2_reg;
  reg sync3_reg;
  reg [1:0] cnt_reg;
  reg busy_reg;

  // Line clock synchroniser and rising edge detect
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      sync3_reg <= 1'b0;
    end else begin
      sync1_reg <= line_clk;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Count two line clock pulses while pending
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 2'h0;
      busy_reg <= 1'b0;
    end else if (start) begin
      cnt_reg <= 2'h0;
      busy_reg <= 1'b1;
    end else if (busy_reg && sync2_reg && !sync3_reg) begin
      if (cnt_reg == `RSIC_LINE_EDGES - 2'h1)
        busy_reg <= 1'b0;
      cnt_reg <= cnt_reg + 2'h1;
    end
  end

  assign done = busy_reg && sync2_reg && !sync3_reg && (cnt_reg == `RSIC_LINE_EDGES - 2'h1);
endmodule

/* File: dv/rsic_checker.sv */
`timescale 1ns/1ps
`include "rsic_consts.vh"
module rsic_checker (
  input wire CLOCK,
  input wire RST_N,
  input wire [3:0] ADDR,
  input wire [31:0] WDATA,
  input wire WR,
  input wire RD,
  input wire LOCAL_BUS_IRQ_IN_N,
  input wire HOST_IRQ_FIRST_OE,
  input wire HOST_IRQ_SECOND_OE,
  input wire DESC_QUEUED,
  input wire FETCH_GLOBAL_DONE,
  input wire TX_SERIAL_DATA_OE,
  input wire PORTS_RUN,
  input wire ACK_PULSE,
  input wire [4:0] OP_PULSE
);
  // Service request write and its opcode
  wire sr = WR && ADDR == `RSIC_A_SREQ;
  wire [4:0] op = WDATA[12:8];
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RST_N);
  //////////////////////////////////////////////////
  // Interrupt lines
  a_irq2_pass: assert property (HOST_IRQ_SECOND_OE == !LOCAL_BUS_IRQ_IN_N)
    else $error("second irq wrong");
  a_irq1_cause: assert property (!HOST_IRQ_FIRST_OE && !DESC_QUEUED |=> !HOST_IRQ_FIRST_OE)
    else $error("first irq without descriptor");
  a_read_clears: assert property (RD && ADDR == `RSIC_A_ISTAT && !DESC_QUEUED |=> !HOST_IRQ_FIRST_OE)
    else $error("first irq kept after read");
  a_hard_float: assert property (disable iff (1'b0) !RST_N |-> !HOST_IRQ_FIRST_OE && !HOST_IRQ_SECOND_OE
    && !TX_SERIAL_DATA_OE)
    else $error("output driven in reset");
  //////////////////////////////////////////////////
  // Service requests
  a_op_decode: assert property (sr |=> OP_PULSE == $past(op))
    else $error("opcode pulse wrong");
  a_ack_plain: assert property (sr && (op == `RSIC_OP_GROUP_INIT || op == `RSIC_OP_GROUP_RESET) |=> ACK_PULSE)
    else $error("missing ack");
  a_scr_no_ack: assert property (sr && op == `RSIC_OP_CHIP_RESET |=> !ACK_PULSE && !TX_SERIAL_DATA_OE
    && !PORTS_RUN)
    else $error("chip reset wrong");
  a_gi_ack_late: assert property (sr && op == `RSIC_OP_GLOBAL_INIT && !FETCH_GLOBAL_DONE |=> !ACK_PULSE)
    else $error("early init ack");
  a_grp_float: assert property (sr && op == `RSIC_OP_GROUP_RESET && WDATA[5] |-> ##2 !TX_SERIAL_DATA_OE)
    else $error("tx data still driven");
  // Main scenarios seen
  c_scr: cover property (sr && op == `RSIC_OP_CHIP_RESET);
  c_ack: cover property (ACK_PULSE);
  c_tx: cover property (TX_SERIAL_DATA_OE);
endmodule

/* File: dv/rsic_far_end.sv */
`timescale 1ns/1ps
`include "rsic_consts.vh"
module rsic_far_end #(
  parameter DLY = 5
) (
  input wire clk,
  input wire rst_n,
  input wire run,
  input wire [4:0] op,
  output reg fetch_g,
  output reg fetch_i,
  output reg tlc,
  output reg rlc
);
  integer cnt_reg;
  // Line clocks toggle only while enabled, parked low otherwise
  initial begin
    tlc = 1'b0;
    rlc = 1'b0;
  end
  always #37 tlc = run ? ~tlc : 1'b0;
  always #61 rlc = run ? ~rlc : 1'b0;
  //////////////////////////////////////////////////
  // Memory answers a global init with both descriptor fetches
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 0;
      fetch_g <= 1'b0;
      fetch_i <= 1'b0;
    end else begin
      cnt_reg <= (op == `RSIC_OP_GLOBAL_INIT) ? DLY : (cnt_reg > 0 ? cnt_reg - 1 : 0);
      fetch_g <= (cnt_reg == 2);
      fetch_i <= (cnt_reg == 1);
    end
  end
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  reg clock = 1'b0;
  reg rst_n = 1'b0;
  reg [3:0] addr = 4'h0;
  reg [31:0] wdata = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg rd_d = 1'b0;
  reg irq_n = 1'b1;
  reg dq = 1'b0;
  reg lc_run = 1'b0;
  wire [31:0] rdata;
  wire [4:0] op;
  wire f1_oe, f2_oe, tx_oe, run, ack, fg, fi, tlc, rlc;
  reg [31:0] exp_q [$];
  reg [31:0] d [0:8];
  integer seed = 55644;
  integer err_total = 0;
  integer compares = 0;
  integer i;
  always #25 clock = ~clock;
  rsic_top dut_u (.CLOCK(clock), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .LOCAL_BUS_IRQ_IN_N(irq_n), .HOST_IRQ_FIRST_N(), .HOST_IRQ_FIRST_OE(f1_oe), .HOST_IRQ_SECOND_N(),
    .HOST_IRQ_SECOND_OE(f2_oe), .DESC_QUEUED(dq), .QUEUE_FULL(1'b0), .FETCH_GLOBAL_DONE(fg),
    .FETCH_IQ_DONE(fi), .TX_LINE_CLOCK(tlc), .RX_LINE_CLOCK(rlc), .TX_SERIAL_DATA_OE(tx_oe),
    .PORTS_RUN(run), .ACK_PULSE(ack), .OP_PULSE(op));
  rsic_far_end far_u (.clk(clock), .rst_n(rst_n), .run(lc_run), .op(op), .fetch_g(fg), .fetch_i(fi),
    .tlc(tlc), .rlc(rlc));
  //////////////////////////////////////////////////
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        err_total = err_total + 1;
        $display("BAD %s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task wr_reg(input [3:0] a, input [31:0] v);
    begin
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
    end
  endtask
  task rd_reg(input [3:0] a, input [31:0] e);
    begin
      @(posedge clock);
      exp_q.push_back(e);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
    end
  endtask
  // Host waits up to 60 cycles for an acknowledge before the next request
  task wait_ack;
    begin
      i = 0;
      while (ack !== 1'b1 && i < 60) begin
        @(negedge clock);
        i = i + 1;
      end
      chk("ack", 32'h1, ack);
    end
  endtask
  task gap(input integer n);
    repeat (n) @(negedge clock);
  endtask
  task print_verdict;
    begin
      $display("errors %0d compares %0d", err_total, compares);
      if (err_total == 0 && compares > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  //////////////////////////////////////////////////
  // Read data compared in the cycle after each read strobe
  always @(posedge clock) begin
    rd_d <= rd;
    if (rd_d && exp_q.size() > 0)
      chk("rdata", exp_q.pop_front(), rdata);
  end
  // Watchdog
  initial begin
    #(3000 * 50);
    err_total = err_total + 1;
    print_verdict;
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 9; i = i + 1)
      rd_reg(i, i == 2 ? 32'h300 : 32'h0);
    rd_reg(4'hb, 32'hffffffff);
    for (i = 0; i < 9; i = i + 1) begin
      d[i] = $random(seed);
      if (i != 6)
        wr_reg(i, d[i]);
    end
    @(posedge clock);
    dq <= 1'b1;
    repeat (3) @(posedge clock);
    dq <= 1'b0;
    gap(1);
    chk("irq1", 32'h1, f1_oe);
    rd_reg(4'h1, {d[1][31:16], 16'h3});
    rd_reg(4'h1, {d[1][31:16], 16'h0});
    rd_reg(4'ha, 32'h3);
    irq_n <= 1'b0;
    gap(2 + ($random(seed) & 7));
    chk("irq2", 32'h1, f2_oe);
    chk("irq1", 32'h0, f1_oe);
    irq_n <= 1'b1;
    wr_reg(4'h6, 32'h300);
    rd_reg(4'h6, 32'h0);
    for (i = 0; i < 9; i = i + 1)
      rd_reg(i, i == 0 ? d[0] & 32'h3 : i == 2 ? 32'h300 : i > 6 ? d[i] : 32'h0);
    rd_reg(4'ha, 32'h0);
    wr_reg(4'h2, 32'h302);
    wr_reg(4'h6, 32'h520);
    gap(4);
    chk("tx_oe", 32'h0, tx_oe);
    lc_run <= 1'b1;
    gap(40);
    wr_reg(4'h6, 32'h100);
    wait_ack;
    gap(2);
    chk("run", 32'h1, run);
    wr_reg(4'h6, 32'h520);
    gap(4);
    chk("tx_oe", 32'h1, tx_oe);
    wr_reg(4'h6, 32'h420);
    gap(2);
    chk("tx_oe", 32'h0, tx_oe);
    gap(12);
    wr_reg(4'h6, 32'h100);
    wait_ack;
    wr_reg(4'h6, 32'h200);
    wait_ack;
    wr_reg(4'h6, 32'h620);
    wait_ack;
    wr_reg(4'h6, 32'h400);
    wait_ack;
    @(posedge clock);
    rst_n <= 1'b0;
    gap(2);
    chk("tx_oe", 32'h0, tx_oe);
    rst_n <= 1'b1;
    rd_reg(4'h2, 32'h300);
    gap(3);
    chk("run", 32'h0, run);
    print_verdict;
  end
endmodule
bind rsic_top rsic_checker chk_u (.CLOCK, .RST_N, .ADDR, .WDATA, .WR, .RD, .LOCAL_BUS_IRQ_IN_N,
  .HOST_IRQ_FIRST_OE, .HOST_IRQ_SECOND_OE, .DESC_QUEUED, .FETCH_GLOBAL_DONE, .TX_SERIAL_DATA_OE,
  .PORTS_RUN, .ACK_PULSE, .OP_PULSE);
